// ---- logic/ppss_pkg.sv ----
// constants, register map and types of the pulse program sequencer
// assumes one reference clock and an apb master with 32-bit data
package ppss_pkg;

    // instruction word layout
    localparam int OUT_W       = 24;
    localparam int DATA_W      = 20;
    localparam int OP_W        = 4;
    localparam int DELAY_W     = 32;
    localparam int WORD_W      = 80;
    localparam int F_OUT_LSB   = 0;
    localparam int F_DATA_LSB  = 24;
    localparam int F_OP_LSB    = 44;
    localparam int F_DELAY_LSB = 48;

    // pin groups
    localparam int HDR_W  = 12;
    localparam int COAX_W = 4;
    localparam int STAT_W = 4;
    localparam int IRQ_W  = 4;

    // opcodes
    localparam logic [OP_W-1:0] OP_CONTINUE = 4'h0;
    localparam logic [OP_W-1:0] OP_STOP     = 4'h1;
    localparam logic [OP_W-1:0] OP_BRANCH   = 4'h2;
    localparam logic [OP_W-1:0] OP_WAIT     = 4'h3;

    // shortest instruction, in reference clock cycles
    localparam logic [DELAY_W-1:0] MIN_DELAY = 32'h5;

    // apb register byte addresses
    localparam int PADDR_W = 8;
    localparam logic [PADDR_W-1:0] ADDR_CTRL       = 8'h00;
    localparam logic [PADDR_W-1:0] ADDR_STATUS     = 8'h04;
    localparam logic [PADDR_W-1:0] ADDR_LOAD_ADDR  = 8'h08;
    localparam logic [PADDR_W-1:0] ADDR_LOAD_OUT   = 8'h0C;
    localparam logic [PADDR_W-1:0] ADDR_LOAD_OP    = 8'h10;
    localparam logic [PADDR_W-1:0] ADDR_LOAD_DELAY = 8'h14;
    localparam logic [PADDR_W-1:0] ADDR_COMMIT     = 8'h18;
    localparam logic [PADDR_W-1:0] ADDR_INT_STS    = 8'h1C;
    localparam logic [PADDR_W-1:0] ADDR_INT_MASK   = 8'h20;
    localparam logic [PADDR_W-1:0] ADDR_COUNT      = 8'h24;

    // control bits (write-only pulses)
    localparam int CTRL_START = 0;
    localparam int CTRL_TRIG  = 1;
    localparam int CTRL_RESET = 2;

    // status line positions on the status header
    localparam int STB_STOPPED = 0;
    localparam int STB_RESET_N = 1;
    localparam int STB_RUNNING = 2;
    localparam int STB_WAITING = 3;

    // interrupt status bits
    localparam int IRQB_STOP    = 0;
    localparam int IRQB_WAIT    = 1;
    localparam int IRQB_RESTART = 2;
    localparam int IRQB_TRIG    = 3;

    // field position of the program counter in the status register
    localparam int STS_PC_LSB = 16;

    // reset values
    localparam logic [OUT_W-1:0]  RST_OUT      = 24'h000000;
    localparam logic [STAT_W-1:0] RST_STATUS   = 4'h0;
    localparam logic [IRQ_W-1:0]  RST_INT_MASK = 4'h0;

    typedef enum logic [1:0] {S_RESET, S_STOP, S_RUN, S_WAIT} ppss_seq_state_t;

endpackage

// ---- logic/ppss_sync_fall.sv ----
// two-flop synchroniser with a falling edge detector
// assumes an idle-high input from a pin; the detector reads only the second flop onward
`timescale 1ns/10ps
module ppss_sync_fall (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic din,
    output logic      level,
    output logic      fall
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } ppss_sync_t;

    ppss_sync_t cur;
    ppss_sync_t nxt;

    always_comb begin
        nxt.meta = din;
        nxt.sync = cur.meta;
        nxt.last = cur.sync;
    end

    // idle high, matching the pull-ups on the pins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= 3'h7;
        end else begin
            cur <= nxt;
        end
    end

    assign level = cur.sync;
    assign fall  = cur.last & ~cur.sync;

endmodule

// ---- logic/ppss_sequencer.sv ----
// pulse program sequencer: program store, execution engine, status lines, apb slave
// assumes an apb master on SYS_CLK and trigger/restart pins from outside the clock domain
`timescale 1ns/10ps
// Contract
// - each instruction drives a 24-bit output word
// - continue advances to the next address
// - branch fetches the data field as address
// - instruction lasts its own delay field
// - low four output bits drive coax lines
// - stopped line high after stop opcode
// - reset line low in reset state
// - running line high only while executing
// - waiting line high after wait opcode
// - outputs on two headers, status on third
// - trigger edge resumes wait or restarts program
// - restart pin returns to first instruction, halted
// - durations from five cycles to 2^32-1
// - all timing counted on one reference clock
module ppss_sequencer
    import ppss_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input  wire logic               SYS_CLK,
    input  wire logic               ARST_N,
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [PADDR_W-1:0] PADDR,
    input  wire logic [31:0]        PWDATA,
    output logic      [31:0]        PRDATA,
    output logic                    PREADY,
    output logic                    PSLVERR,
    input  wire logic               EXT_TRIGGER_N,
    input  wire logic               EXT_RESTART_N,
    output logic      [HDR_W-1:0]   LOW_OUTPUT_HEADER,
    output logic      [HDR_W-1:0]   HIGH_OUTPUT_HEADER,
    output logic      [STAT_W-1:0]  STATUS_HEADER,
    output logic      [COAX_W-1:0]  COAX_OUT,
    output logic                    IRQ
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WORD_W-1:0] mem;
        ppss_seq_state_t              state;
        logic [AW-1:0]                pc;
        logic [DELAY_W-1:0]           cnt;
        logic [OUT_W-1:0]             out_word;
        logic [OP_W-1:0]              op;
        logic [DATA_W-1:0]            data;
        logic                         ld;
        logic [STAT_W-1:0]            status;
        logic [COAX_W-1:0]            coax;
        logic [AW-1:0]                ld_addr;
        logic [OUT_W-1:0]             stg_out;
        logic [DATA_W-1:0]            stg_data;
        logic [OP_W-1:0]              stg_op;
        logic [DELAY_W-1:0]           stg_delay;
        logic [IRQ_W-1:0]             int_sts;
        logic [IRQ_W-1:0]             int_mask;
        logic                         irq;
        logic                         pready;
        logic                         pslverr;
        logic [31:0]                  prdata;
    } ppss_regs_t;

    ppss_regs_t cur;
    ppss_regs_t nxt;

    logic trig_fall;
    logic rst_level;
    logic acc;
    logic wr_en;
    logic ctrl_wr;
    logic sw_start;
    logic sw_trig;
    logic sw_reset;
    logic restart_low;
    logic trig_evt;
    logic ovr;
    logic expire;
    logic addr_ok;

    // both pins pass two flops before anything looks at them
    ppss_sync_fall u_trig_sync (
        .clk    (SYS_CLK),
        .arst_n (ARST_N),
        .din    (EXT_TRIGGER_N),
        .level  (),
        .fall   (trig_fall)
    );

    ppss_sync_fall u_rst_sync (
        .clk    (SYS_CLK),
        .arst_n (ARST_N),
        .din    (EXT_RESTART_N),
        .level  (rst_level),
        .fall   ()
    );

    // first access cycle computes the answer, pready rises one cycle later
    assign acc         = PSEL && PENABLE && !cur.pready;
    assign wr_en       = PSEL && PENABLE && cur.pready && PWRITE && !cur.pslverr;
    assign ctrl_wr     = wr_en && (PADDR == ADDR_CTRL);
    assign sw_start    = ctrl_wr && PWDATA[CTRL_START];
    assign sw_trig     = ctrl_wr && PWDATA[CTRL_TRIG];
    assign sw_reset    = ctrl_wr && PWDATA[CTRL_RESET];
    assign restart_low = !rst_level;
    // a trigger only counts while the engine is idle
    assign trig_evt    = (trig_fall || sw_trig) && (cur.state != S_RUN);
    assign ovr         = restart_low || sw_reset;
    assign expire      = (cur.state == S_RUN) && (cur.cnt == '0);

    always_comb begin
        case (PADDR)
            ADDR_CTRL, ADDR_STATUS, ADDR_LOAD_ADDR, ADDR_LOAD_OUT, ADDR_LOAD_OP,
            ADDR_LOAD_DELAY, ADDR_COMMIT, ADDR_INT_STS, ADDR_INT_MASK,
            ADDR_COUNT: addr_ok = 1'b1;
            default:    addr_ok = 1'b0;
        endcase
    end

    // fetch one word: outputs, opcode, data and count all change on the same edge
    function automatic ppss_regs_t f_load(input ppss_regs_t s, input logic [AW-1:0] a);
        ppss_regs_t        r;
        logic [WORD_W-1:0] w;
        logic [DELAY_W-1:0] d;
        r = s;
        w = s.mem[a];
        d = w[F_DELAY_LSB +: DELAY_W];
        r.pc       = a;
        r.out_word = w[F_OUT_LSB +: OUT_W];
        r.op       = w[F_OP_LSB +: OP_W];
        r.data     = w[F_DATA_LSB +: DATA_W];
        // short delays are stretched to the minimum the engine can turn around in
        r.cnt      = (d < MIN_DELAY) ? (MIN_DELAY - 32'h1) : (d - 32'h1);
        r.ld       = 1'b1;
        r.state    = S_RUN;
        return r;
    endfunction

    always_comb begin
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] clr;
        ev  = '0;
        clr = '0;
        nxt = cur;
        nxt.ld     = 1'b0;
        nxt.pready = acc;

        // bus answer, computed in the first access cycle and held until the next one
        if (acc) begin
            nxt.pslverr = !addr_ok;
            case (PADDR)
                ADDR_STATUS:     nxt.prdata = {16'(cur.pc), 12'h000, cur.status};
                ADDR_LOAD_ADDR:  nxt.prdata = 32'(cur.ld_addr);
                ADDR_LOAD_OUT:   nxt.prdata = 32'(cur.stg_out);
                ADDR_LOAD_OP:    nxt.prdata = {4'h0, cur.stg_op, 4'h0, cur.stg_data};
                ADDR_LOAD_DELAY: nxt.prdata = cur.stg_delay;
                ADDR_INT_STS:    nxt.prdata = 32'(cur.int_sts);
                ADDR_INT_MASK:   nxt.prdata = 32'(cur.int_mask);
                ADDR_COUNT:      nxt.prdata = cur.cnt;
                default:         nxt.prdata = 32'h00000000;
            endcase
        end

        if (wr_en) begin
            case (PADDR)
                ADDR_LOAD_ADDR:  nxt.ld_addr   = PWDATA[AW-1:0];
                ADDR_LOAD_OUT:   nxt.stg_out   = PWDATA[OUT_W-1:0];
                ADDR_LOAD_OP: begin
                    nxt.stg_data = PWDATA[DATA_W-1:0];
                    nxt.stg_op   = PWDATA[24 +: OP_W];
                end
                ADDR_LOAD_DELAY: nxt.stg_delay = PWDATA;
                // the loaded word lands at the load pointer, which then steps on
                ADDR_COMMIT: begin
                    nxt.mem[cur.ld_addr] = {cur.stg_delay, cur.stg_op, cur.stg_data,
                                            cur.stg_out};
                    nxt.ld_addr          = cur.ld_addr + AW'(1);
                end
                ADDR_INT_STS:    clr           = PWDATA[IRQ_W-1:0];
                ADDR_INT_MASK:   nxt.int_mask  = PWDATA[IRQ_W-1:0];
                default: begin
                end
            endcase
        end

        // execution engine; restart pin has priority over everything
        if (restart_low) begin
            nxt.state = S_RESET;
            nxt.pc    = '0;
            nxt.cnt   = '0;
            ev[IRQB_RESTART] = (cur.state != S_RESET);
        end else if (sw_reset) begin
            nxt.state = S_RESET;
            nxt.pc    = '0;
            nxt.cnt   = '0;
        end else if (sw_start && cur.state != S_RUN) begin
            nxt = f_load(nxt, '0);
        end else if (trig_evt) begin
            ev[IRQB_TRIG] = 1'b1;
            if (cur.state == S_WAIT) begin
                nxt = f_load(nxt, cur.pc + AW'(1));
            end else begin
                nxt = f_load(nxt, '0);
            end
        end else if (cur.state == S_RUN) begin
            if (cur.cnt != '0) begin
                nxt.cnt = cur.cnt - 32'h1;
            end else begin
                case (cur.op)
                    OP_STOP: begin
                        nxt.state       = S_STOP;
                        ev[IRQB_STOP]   = 1'b1;
                    end
                    OP_WAIT: begin
                        nxt.state       = S_WAIT;
                        ev[IRQB_WAIT]   = 1'b1;
                    end
                    OP_BRANCH: nxt = f_load(nxt, cur.data[AW-1:0]);
                    // data field is ignored here, the loader stores it as written
                    default:   nxt = f_load(nxt, cur.pc + AW'(1));
                endcase
            end
        end

        nxt.status[STB_STOPPED] = (nxt.state == S_STOP);
        nxt.status[STB_RESET_N] = (nxt.state != S_RESET);
        nxt.status[STB_RUNNING] = (nxt.state == S_RUN);
        nxt.status[STB_WAITING] = (nxt.state == S_WAIT);
        nxt.coax                = nxt.out_word[COAX_W-1:0];

        // a new event in the clearing cycle wins over the clear
        nxt.int_sts = (cur.int_sts & ~clr) | ev;
        nxt.irq     = |(nxt.int_sts & nxt.int_mask);
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cur          <= '0;
            cur.state    <= S_RESET;
            cur.out_word <= RST_OUT;
            cur.status   <= RST_STATUS;
            cur.int_mask <= RST_INT_MASK;
        end else begin
            cur <= nxt;
        end
    end

    // one flop bank feeds both headers, so every bit switches together
    assign LOW_OUTPUT_HEADER  = cur.out_word[HDR_W-1:0];
    assign HIGH_OUTPUT_HEADER = cur.out_word[OUT_W-1:HDR_W];
    assign STATUS_HEADER      = cur.status;
    assign COAX_OUT           = cur.coax;
    assign IRQ                = cur.irq;
    assign PRDATA             = cur.prdata;
    assign PREADY             = cur.pready;
    assign PSLVERR            = cur.pslverr;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!ARST_N);

    property p_word_loaded;
        cur.ld |-> {HIGH_OUTPUT_HEADER, LOW_OUTPUT_HEADER}
                   == cur.mem[cur.pc][F_OUT_LSB +: OUT_W];
    endproperty
    a_word_loaded: assert property (p_word_loaded)
        else $error("output word differs from fetch");

    property p_continue_step;
        expire && cur.op == OP_CONTINUE && !ovr && !sw_start
            |=> cur.pc == $past(cur.pc) + AW'(1) && cur.ld;
    endproperty
    a_continue_step: assert property (p_continue_step)
        else $error("continue did not advance");

    property p_branch_target;
        expire && cur.op == OP_BRANCH && !ovr && !sw_start
            |=> cur.pc == $past(cur.data[AW-1:0]) && cur.ld;
    endproperty
    a_branch_target: assert property (p_branch_target)
        else $error("branch went elsewhere");

    property p_hold_min;
        cur.ld |-> ##1 (!cur.ld)[*4];
    endproperty
    a_hold_min: assert property (p_hold_min)
        else $error("instruction shorter than minimum");

    property p_coax_copy;
        COAX_OUT == LOW_OUTPUT_HEADER[COAX_W-1:0];
    endproperty
    a_coax_copy: assert property (p_coax_copy)
        else $error("coax lines differ from low bits");

    property p_stop_line;
        expire && cur.op == OP_STOP && !ovr && !sw_start
            |=> STATUS_HEADER[STB_STOPPED] && !STATUS_HEADER[STB_RUNNING];
    endproperty
    a_stop_line: assert property (p_stop_line)
        else $error("stopped line not raised");

    property p_reset_line;
        cur.state == S_RESET |-> !STATUS_HEADER[STB_RESET_N] && !STATUS_HEADER[STB_RUNNING];
    endproperty
    a_reset_line: assert property (p_reset_line)
        else $error("reset line high in reset");

    property p_run_line;
        STATUS_HEADER[STB_RUNNING] == (cur.state == S_RUN);
    endproperty
    a_run_line: assert property (p_run_line)
        else $error("running line wrong");

    property p_wait_line;
        expire && cur.op == OP_WAIT && !ovr && !sw_start
            |=> STATUS_HEADER[STB_WAITING] until trig_evt || ovr || sw_start;
    endproperty
    a_wait_line: assert property (p_wait_line)
        else $error("waiting line dropped early");

    property p_trig_resume;
        cur.state == S_WAIT && trig_evt && !ovr && !sw_start
            |=> cur.pc == $past(cur.pc) + AW'(1) && STATUS_HEADER[STB_RUNNING];
    endproperty
    a_trig_resume: assert property (p_trig_resume)
        else $error("wait did not resume");

    property p_restart;
        restart_low
            |=> cur.pc == '0 && !STATUS_HEADER[STB_RUNNING] && !STATUS_HEADER[STB_RESET_N];
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart did not halt at start");

    property p_sync_change;
        !$stable({HIGH_OUTPUT_HEADER, LOW_OUTPUT_HEADER}) |-> cur.ld;
    endproperty
    a_sync_change: assert property (p_sync_change)
        else $error("outputs changed off a boundary");

endmodule

// ---- bench/ppss_instr_model.sv ----
// far side of the sequencer: trigger and restart sources plus the instrument reading the pins
// assumes requests from the bench arrive as levels changed right after a rising clock edge
`timescale 1ns/10ps
module ppss_instr_model
    import ppss_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              trig_req,
    input  wire logic              restart_hold,
    input  wire logic [HDR_W-1:0]  low_hdr,
    input  wire logic [HDR_W-1:0]  high_hdr,
    input  wire logic [COAX_W-1:0] coax,
    output logic                   trig_n,
    output logic                   restart_n,
    output logic [OUT_W-1:0]       word,
    output logic [COAX_W-1:0]      coax_seen
);
    logic [2:0] low_cnt_ff = 3'h0;

    // pins idle at their pull-up level; a trigger is a clean low pulse long enough for the sync
    always_ff @(posedge clk) begin
        if (trig_req && low_cnt_ff == 3'h0) begin
            low_cnt_ff <= 3'h4;
        end else if (low_cnt_ff != 3'h0) begin
            low_cnt_ff <= low_cnt_ff - 3'h1;
        end
    end
    assign trig_n    = (low_cnt_ff == 3'h0);
    assign restart_n = !restart_hold;
    // instrument view: both headers joined back into one word, and the coax lines
    assign word      = {high_hdr, low_hdr};
    assign coax_seen = coax;
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench of the pulse program sequencer
// assumes the apb slave answers with one wait state and pins pass a two-flop sync
`timescale 1ns/10ps
module tb_top;
    import ppss_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, irq, trig_req = 1'b0, restart_hold = 1'b0, trig_n, restart_n;
    logic [HDR_W-1:0] low_hdr, high_hdr;
    logic [STAT_W-1:0] stat;
    logic [COAX_W-1:0] coax, coax_seen;
    logic [OUT_W-1:0] word;
    int n_mismatch = 0, comparisons = 0, cnt;

    always #50 clk = ~clk;

    ppss_sequencer #(.DEPTH(16)) dut_u (.SYS_CLK(clk), .ARST_N(arst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EXT_TRIGGER_N(trig_n), .EXT_RESTART_N(restart_n),
        .LOW_OUTPUT_HEADER(low_hdr), .HIGH_OUTPUT_HEADER(high_hdr), .STATUS_HEADER(stat),
        .COAX_OUT(coax), .IRQ(irq));
    ppss_instr_model far_u (.clk(clk), .trig_req(trig_req), .restart_hold(restart_hold),
        .low_hdr(low_hdr), .high_hdr(high_hdr), .coax(coax), .trig_n(trig_n),
        .restart_n(restart_n), .word(word), .coax_seen(coax_seen));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) check("pready", 32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // waits for a new output word; every cycle before it must still show the old one
    task automatic wait_word(input logic [23:0] prev, input logic [23:0] exp, input int lim);
        logic torn;
        torn = 1'b0;
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
            if (word !== exp && word !== prev) torn = 1'b1;
        end while (word !== exp && cnt < lim);
        check("output word", {8'h0, word}, {8'h0, exp});
        check("coax lines", {28'h0, coax_seen}, {28'h0, exp[3:0]});
        check("no torn word", {31'h0, torn}, 32'h0);
    endtask

    task automatic load(input int i, input logic [23:0] o, input logic [3:0] op,
                        input logic [19:0] d, input logic [31:0] dly);
        if (i == 0) apb(1'b1, ADDR_LOAD_ADDR, 32'h0);
        apb(1'b1, ADDR_LOAD_OUT, {8'h0, o});
        apb(1'b1, ADDR_LOAD_OP, {4'h0, op, 4'h0, d});
        apb(1'b1, ADDR_LOAD_DELAY, dly);
        apb(1'b1, ADDR_COMMIT, 32'h0);
    endtask

    task automatic pulse_trigger();
        @(posedge clk);
        trig_req <= 1'b1;
        @(posedge clk);
        trig_req <= 1'b0;
    endtask

    task automatic test_reset_state();
        check("status after reset", {28'h0, stat}, 32'h0);
        check("word after reset", {8'h0, word}, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        $display("test reset_state done");
    endtask

    task automatic test_program_flow();
        load(0, 24'hFFFFFF, OP_CONTINUE, 20'h0, 32'd5);
        load(1, 24'h000A5A, OP_BRANCH, 20'h3, 32'd7);
        load(2, 24'h111111, OP_STOP, 20'h0, 32'd5);
        load(3, 24'h0000F0, OP_WAIT, 20'h0, 32'd6);
        load(4, 24'h123456, OP_STOP, 20'h0, 32'd2);
        apb(1'b1, ADDR_INT_MASK, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h1);
        wait_word(24'h000000, 24'hFFFFFF, 4);
        check("running", {28'h0, stat}, 32'h6);
        wait_word(24'hFFFFFF, 24'h000A5A, 9);
        check("continue interval", cnt, 5);
        wait_word(24'h000A5A, 24'h0000F0, 12);
        check("branch interval", cnt, 7);
        repeat (5) @(negedge clk);
        check("wait not early", {28'h0, stat}, 32'h6);
        @(negedge clk);
        check("waiting", {28'h0, stat}, 32'hA);
        check("masked wait irq", {31'h0, irq}, 32'h0);
        $display("test program_flow done");
    endtask

    task automatic test_trigger_stop();
        pulse_trigger();
        wait_word(24'h0000F0, 24'h123456, 12);
        repeat (4) @(negedge clk);
        check("stop not early", {28'h0, stat}, 32'h6);
        @(negedge clk);
        check("stopped", {28'h0, stat}, 32'h3);
        repeat (2) @(negedge clk);
        check("stop irq", {31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_INT_STS, 32'h1);
        repeat (2) @(negedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        apb(1'b0, ADDR_INT_STS, 32'h0);
        check("sticky bits", {28'h0, rd[3:0]}, 32'hA);
        pulse_trigger();
        wait_word(24'h123456, 24'hFFFFFF, 12);
        $display("test trigger_stop done");
    endtask

    task automatic test_restart_pin();
        @(posedge clk);
        restart_hold <= 1'b1;
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (stat !== 4'h0 && cnt < 8);
        check("reset state", {28'h0, stat}, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("pc at start", {16'h0, rd[31:16]}, 32'h0);
        @(posedge clk);
        restart_hold <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b1, ADDR_CTRL, 32'h1);
        wait_word(word, 24'hFFFFFF, 4);
        @(negedge clk);
        check("resumed running", {28'h0, stat}, 32'h6);
        // the last four cycles of the first interval prove the restart began at the first instruction
        wait_word(24'hFFFFFF, 24'h000A5A, 9);
        check("restart from first", cnt, 4);
        $display("test restart_pin done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(negedge clk);
        test_reset_state();
        test_program_flow();
        test_trigger_stop();
        test_restart_pin();
        tally_and_finish();
    end

    // the whole run needs under 1000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
